// ===== hw/bhu_pkg.sv
/*
  Shared constants and types for both ends of the serial host link with power-up handshake.
  Assumes a single 50 MHz core clock at each end.
*/
package bhu_pkg;
  // Core clock and link rates.
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD_DEFAULT = 115_200;
  localparam int BAUD_MIN = 37_500;
  localparam int BAUD_MAX = 4_000_000;
  localparam int BAUD_MAX_FREF_19M2 = 3_840_000;
  // Allowed rate error in tenths of a percent, low side and high side.
  localparam int RATE_ERR_LOW_PERMILLE = 25;
  localparam int RATE_ERR_HIGH_PERMILLE = 15;
  // Frame and buffer shape.
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int HOST_FIFO_DEPTH = 2;
  localparam int HOST_STOP_BYTES = 16;
  // Power-up: device must drop its request-to-send within this time of enable.
  localparam int READY_MS = 100;
  localparam int READY_CYC = READY_MS * (CLK_HZ / 1000);
  // Host: slow clock stable within this time of enable.
  localparam int SLOW_STABLE_MS = 2;
  localparam int SLOW_STABLE_CYC = SLOW_STABLE_MS * (CLK_HZ / 1000);
  localparam int SLOW_CLK_HZ = 32_768;
  localparam int SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_CLK_HZ);
  // Lag from a flow-control low level to the first start bit.
  localparam int FLOW_LAG_NS = 2000;
  localparam int FLOW_LAG_CYC = (FLOW_LAG_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Device power-up states.
  typedef enum logic [1:0] {
    BHU_PWR_OFF = 2'b00,
    BHU_PWR_WAIT = 2'b01,
    BHU_PWR_READY = 2'b10
  } bhu_pwr_type;

  // Host sequencing states.
  typedef enum logic [1:0] {
    BHU_HST_HOLD = 2'b00,
    BHU_HST_ENABLE = 2'b01,
    BHU_HST_LINK = 2'b10
  } bhu_host_type;
endpackage

// ===== hw/bhu_link_if.sv
/*
  Pin-level link between the device end and the host end.
  Assumes both ends share one clock in simulation; the interface holds wires only.
*/
`timescale 1ns/1ps
interface bhu_link_if;
  logic dev_txd;
  logic host_txd;
  logic dev_rts_n;
  logic dev_cts_n;
  logic bluetooth_enable_pin;
  logic slow_clock_signal;

  modport dev_end(output dev_txd, output dev_rts_n, input host_txd, input dev_cts_n,
    input bluetooth_enable_pin, input slow_clock_signal);
  modport host_end(input dev_txd, input dev_rts_n, output host_txd, output dev_cts_n,
    output bluetooth_enable_pin, output slow_clock_signal);
endinterface

// ===== hw/bhu_dev_end.sv
/*
  Device end of the serial host link: power-up handshake, flow control, and the
  buffered serial engine; also holds the FIFO that the host end reuses.
  Assumes all link inputs are synchronous to i_core_clk and the enable pin acts as reset.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO with registered flags.
module bhu_fifo #(
  parameter int WIDTH = bhu_pkg::DATA_W,
  parameter int DEPTH = bhu_pkg::FIFO_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clear,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready,
  output logic [$clog2(DEPTH+1)-1:0] o_level
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;
  logic [LW-1:0] next_level;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr];

  // Level follows push and pop; flags are registered so ready never depends on the far side.
  always_comb begin
    next_level = o_level;
    if (push && !pop) begin
      next_level = o_level + LW'(1);
    end else if (pop && !push) begin
      next_level = o_level - LW'(1);
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      o_level <= '0;
      o_in_ready <= 1'b0;
      o_out_valid <= 1'b0;
    end else if (i_clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      o_level <= '0;
      o_in_ready <= 1'b0;
      o_out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      o_level <= next_level;
      o_in_ready <= (next_level != LW'(DEPTH));
      o_out_valid <= (next_level != '0);
    end
  end

  // Storage has no reset; only written words are ever read.
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Device end: power-up sequencing, request-to-send, and buffered data both ways.
module bhu_dev_end #(
  parameter int DATA_W = bhu_pkg::DATA_W,
  parameter int DEPTH = bhu_pkg::FIFO_DEPTH,
  parameter int BAUD = bhu_pkg::BAUD_DEFAULT,
  parameter bit PARITY_EN = 1'b0,
  parameter bit PARITY_ODD = 1'b0,
  parameter int READY_CYC = bhu_pkg::READY_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  bhu_link_if.dev_end link,
  input wire logic i_tx_valid,
  input wire logic [DATA_W-1:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [DATA_W-1:0] o_rx_data,
  input wire logic i_rx_ready,
  output logic o_powered,
  output logic o_rx_drop
);
  localparam int CW = $clog2(READY_CYC + 1);
  localparam int LW = $clog2(DEPTH + 1);
  // RTS rises once three quarters of the receive FIFO hold data.
  localparam int RTS_HIGH_LEVEL = DEPTH - DEPTH / 4;

  bhu_pkg::bhu_pwr_type state;
  logic [CW-1:0] pwr_cnt;
  logic slow_seen;
  logic slow_last;
  logic idle;
  logic eng_tx_valid;
  logic [DATA_W-1:0] eng_tx_data;
  logic eng_tx_ready;
  logic eng_rx_valid;
  logic [DATA_W-1:0] eng_rx_data;
  logic eng_rx_err;
  logic rx_in_ready;
  logic [LW-1:0] rx_level;

  assign idle = (state != bhu_pkg::BHU_PWR_READY);

  // Enable low holds everything off; readiness needs the delay and a live slow clock.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= bhu_pkg::BHU_PWR_OFF;
      pwr_cnt <= '0;
      slow_seen <= 1'b0;
      slow_last <= 1'b0;
    end else begin
      slow_last <= link.slow_clock_signal;
      unique case (state)
        bhu_pkg::BHU_PWR_OFF: begin
          pwr_cnt <= '0;
          slow_seen <= 1'b0;
          if (link.bluetooth_enable_pin) begin
            state <= bhu_pkg::BHU_PWR_WAIT;
          end
        end
        bhu_pkg::BHU_PWR_WAIT: begin
          if (link.slow_clock_signal != slow_last) begin
            slow_seen <= 1'b1;
          end
          if (pwr_cnt != CW'(READY_CYC - 1)) begin
            pwr_cnt <= pwr_cnt + CW'(1);
          end
          if (!link.bluetooth_enable_pin) begin
            state <= bhu_pkg::BHU_PWR_OFF;
          end else if (pwr_cnt == CW'(READY_CYC - 1) && slow_seen) begin
            state <= bhu_pkg::BHU_PWR_READY;
          end
        end
        bhu_pkg::BHU_PWR_READY: begin
          if (!link.bluetooth_enable_pin) begin
            state <= bhu_pkg::BHU_PWR_OFF;
          end
        end
        default: begin
          state <= bhu_pkg::BHU_PWR_OFF;
        end
      endcase
    end
  end

  // RTS low only when ready and the receive FIFO has room for the host's run-on bytes.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      link.dev_rts_n <= 1'b1;
      o_powered <= 1'b0;
    end else begin
      link.dev_rts_n <= idle || (rx_level >= LW'(RTS_HIGH_LEVEL));
      o_powered <= !idle;
    end
  end

  // Bytes with a bad stop or parity bit are dropped, as are bytes that find the FIFO full.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_drop <= 1'b0;
    end else begin
      o_rx_drop <= eng_rx_valid && (eng_rx_err || !rx_in_ready);
    end
  end

  bhu_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clear(idle),
    .i_in_valid(i_tx_valid),
    .i_in_data(i_tx_data),
    .o_in_ready(o_tx_ready),
    .o_out_valid(eng_tx_valid),
    .o_out_data(eng_tx_data),
    .i_out_ready(eng_tx_ready),
    .o_level()
  );

  bhu_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clear(idle),
    .i_in_valid(eng_rx_valid && !eng_rx_err),
    .i_in_data(eng_rx_data),
    .o_in_ready(rx_in_ready),
    .o_out_valid(o_rx_valid),
    .o_out_data(o_rx_data),
    .i_out_ready(i_rx_ready),
    .o_level(rx_level)
  );

  bhu_serial #(.DATA_W(DATA_W), .BAUD(BAUD), .PARITY_EN(PARITY_EN), .PARITY_ODD(PARITY_ODD)) u_serial (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clear(idle),
    .i_cts_n(link.dev_cts_n),
    .i_tx_valid(eng_tx_valid),
    .i_tx_data(eng_tx_data),
    .o_tx_ready(eng_tx_ready),
    .o_txd(link.dev_txd),
    .i_rxd(link.host_txd),
    .o_rx_valid(eng_rx_valid),
    .o_rx_data(eng_rx_data),
    .o_rx_err(eng_rx_err)
  );
endmodule

// ===== hw/bhu_host_end.sv
/*
  Host end of the serial link: enable sequencing, slow clock source, flow control; also
  holds the serial engine that the device end reuses.
  Assumes the package is compiled first, the FIFO comes from the device end file, and
  inputs are synchronous to i_core_clk.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Serial engine: one transmitter gated by a clear-to-send level and one receiver.
module bhu_serial #(
  parameter int DATA_W = bhu_pkg::DATA_W,
  parameter int BAUD = bhu_pkg::BAUD_DEFAULT,
  parameter bit PARITY_EN = 1'b0,
  parameter bit PARITY_ODD = 1'b0
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_clear,
  input wire logic i_cts_n,
  input wire logic i_tx_valid,
  input wire logic [DATA_W-1:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_txd,
  input wire logic i_rxd,
  output logic o_rx_valid,
  output logic [DATA_W-1:0] o_rx_data,
  output logic o_rx_err
);
  // The rate is capped at the ceiling that holds for every reference clock, so one build
  // serves all of them, and raised to the floor of the band.
  localparam int BAUD_CAP = (BAUD > bhu_pkg::BAUD_MAX_FREF_19M2) ? bhu_pkg::BAUD_MAX_FREF_19M2 : BAUD;
  localparam int BAUD_USE = (BAUD_CAP < bhu_pkg::BAUD_MIN) ? bhu_pkg::BAUD_MIN : BAUD_CAP;
  // Divide-down of the core clock; at 50 MHz the rate error stays well inside the band
  // up to about 1 Mbps, above that the integer divider can leave it.
  localparam int CPB = bhu_pkg::CLK_HZ / BAUD_USE;
  localparam int BW = $clog2(CPB);
  localparam int RW = DATA_W + int'(PARITY_EN);
  localparam int PW = RW + 1;
  localparam int FW = PW + 1;
  localparam int NW = $clog2(FW + 1);
  localparam int LAGW = $clog2(bhu_pkg::FLOW_LAG_CYC + 1);

  logic [LAGW-1:0] lag_cnt;
  logic go;
  logic tx_busy;
  logic [PW-1:0] tx_frame;
  logic [PW-1:0] tx_shift;
  logic [NW-1:0] tx_bits;
  logic [BW-1:0] tx_baud;
  logic rx_busy;
  logic [RW-1:0] rx_shift;
  logic [NW-1:0] rx_bits;
  logic [BW-1:0] rx_baud;
  logic rx_par_bad;

  // Stop bit, optional parity, then data; shifted out from the low end.
  if (PARITY_EN) begin : g_par
    assign tx_frame = {1'b1, ^i_tx_data ^ PARITY_ODD, i_tx_data};
    assign rx_par_bad = (^rx_shift) != PARITY_ODD;
  end else begin : g_nopar
    assign tx_frame = {1'b1, i_tx_data};
    assign rx_par_bad = 1'b0;
  end

  // A new character may start only after the clear-to-send level has been low for the lag.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      lag_cnt <= '0;
    end else if (i_clear || i_cts_n) begin
      lag_cnt <= '0;
    end else if (lag_cnt != LAGW'(bhu_pkg::FLOW_LAG_CYC)) begin
      lag_cnt <= lag_cnt + LAGW'(1);
    end
  end

  assign go = (lag_cnt == LAGW'(bhu_pkg::FLOW_LAG_CYC));
  assign o_tx_ready = !tx_busy && go;

  // A character already on the wire finishes unless i_clear aborts it, so at most one more byte follows CTS high.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_busy <= 1'b0;
      o_txd <= 1'b1;
      tx_shift <= '1;
      tx_bits <= '0;
      tx_baud <= '0;
    end else if (i_clear) begin
      tx_busy <= 1'b0;
      o_txd <= 1'b1;
      tx_bits <= '0;
      tx_baud <= '0;
    end else if (!tx_busy) begin
      if (i_tx_valid && go) begin
        tx_busy <= 1'b1;
        o_txd <= 1'b0;
        tx_shift <= tx_frame;
        tx_bits <= NW'(FW - 1);
        tx_baud <= '0;
      end
    end else if (tx_baud == BW'(CPB - 1)) begin
      tx_baud <= '0;
      if (tx_bits == '0) begin
        tx_busy <= 1'b0;
      end else begin
        o_txd <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[PW-1:1]};
        tx_bits <= tx_bits - NW'(1);
      end
    end else begin
      tx_baud <= tx_baud + BW'(1);
    end
  end

  // Receiver samples mid-bit; a start bit that is high again at mid-bit is a glitch.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_busy <= 1'b0;
      rx_shift <= '0;
      rx_bits <= '0;
      rx_baud <= '0;
      o_rx_valid <= 1'b0;
      o_rx_data <= '0;
      o_rx_err <= 1'b0;
    end else if (i_clear) begin
      rx_busy <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_err <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      o_rx_err <= 1'b0;
      if (!rx_busy) begin
        if (!i_rxd) begin
          rx_busy <= 1'b1;
          rx_bits <= NW'(FW);
          rx_baud <= BW'(CPB / 2);
        end
      end else if (rx_baud == '0) begin
        rx_baud <= BW'(CPB - 1);
        rx_bits <= rx_bits - NW'(1);
        if (rx_bits == NW'(FW)) begin
          rx_busy <= !i_rxd;
        end else if (rx_bits == NW'(1)) begin
          rx_busy <= 1'b0;
          o_rx_valid <= 1'b1;
          o_rx_data <= rx_shift[DATA_W-1:0];
          o_rx_err <= !i_rxd || rx_par_bad;
        end else begin
          rx_shift <= {i_rxd, rx_shift[RW-1:1]};
        end
      end else begin
        rx_baud <= rx_baud - BW'(1);
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module bhu_host_end #(
  parameter int DATA_W = bhu_pkg::DATA_W,
  parameter int DEPTH = bhu_pkg::HOST_FIFO_DEPTH,
  parameter int BAUD = bhu_pkg::BAUD_DEFAULT,
  parameter bit PARITY_EN = 1'b0,
  parameter bit PARITY_ODD = 1'b0
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  bhu_link_if.host_end link,
  input wire logic i_io_supply_good,
  input wire logic i_bt_on,
  output logic o_link_up,
  input wire logic i_tx_valid,
  input wire logic [DATA_W-1:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [DATA_W-1:0] o_rx_data,
  input wire logic i_rx_ready,
  output logic o_rx_err
);
  // Same capped rate as the serial engine, so the clear-to-send hold is a full bit.
  localparam int BAUD_CAP = (BAUD > bhu_pkg::BAUD_MAX_FREF_19M2) ? bhu_pkg::BAUD_MAX_FREF_19M2 : BAUD;
  localparam int CPB = bhu_pkg::CLK_HZ / BAUD_CAP;
  localparam int BW = $clog2(CPB + 1);
  localparam int SW = $clog2(bhu_pkg::SLOW_HALF_CYC + 1);
  localparam int LW = $clog2(DEPTH + 1);

  bhu_pkg::bhu_host_type state;
  logic [SW-1:0] slow_cnt;
  logic slow_run;
  logic [BW-1:0] cts_hi_cnt;
  logic idle;
  logic eng_tx_valid;
  logic [DATA_W-1:0] eng_tx_data;
  logic eng_tx_ready;
  logic eng_rx_valid;
  logic [DATA_W-1:0] eng_rx_data;
  logic eng_rx_err;
  logic [LW-1:0] rx_level;

  assign idle = (state != bhu_pkg::BHU_HST_LINK);

  // Slow clock runs from reset on; enable may rise as soon as it has toggled once (slow_run).
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      slow_cnt <= '0;
      link.slow_clock_signal <= 1'b0;
      slow_run <= 1'b0;
    end else if (slow_cnt == SW'(bhu_pkg::SLOW_HALF_CYC - 1)) begin
      slow_cnt <= '0;
      link.slow_clock_signal <= !link.slow_clock_signal;
      slow_run <= 1'b1;
    end else begin
      slow_cnt <= slow_cnt + SW'(1);
    end
  end

  // Enable stays low until the supply is good; link is up once the device drops RTS.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= bhu_pkg::BHU_HST_HOLD;
      link.bluetooth_enable_pin <= 1'b0;
      o_link_up <= 1'b0;
    end else begin
      unique case (state)
        bhu_pkg::BHU_HST_HOLD: begin
          if (i_bt_on && i_io_supply_good && slow_run) begin
            state <= bhu_pkg::BHU_HST_ENABLE;
            link.bluetooth_enable_pin <= 1'b1;
          end
        end
        bhu_pkg::BHU_HST_ENABLE: begin
          if (!i_bt_on || !i_io_supply_good) begin
            state <= bhu_pkg::BHU_HST_HOLD;
            link.bluetooth_enable_pin <= 1'b0;
          end else if (!link.dev_rts_n) begin
            state <= bhu_pkg::BHU_HST_LINK;
            o_link_up <= 1'b1;
          end
        end
        bhu_pkg::BHU_HST_LINK: begin
          if (!i_bt_on || !i_io_supply_good) begin
            state <= bhu_pkg::BHU_HST_HOLD;
            link.bluetooth_enable_pin <= 1'b0;
            o_link_up <= 1'b0;
          end
        end
        default: begin
          state <= bhu_pkg::BHU_HST_HOLD;
          link.bluetooth_enable_pin <= 1'b0;
          o_link_up <= 1'b0;
        end
      endcase
    end
  end

  // CTS rises whenever a byte waits, keeping one slot for the device's run-on byte,
  // and once high it stays high for at least one bit period.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      link.dev_cts_n <= 1'b1;
      cts_hi_cnt <= '0;
    end else if (idle || rx_level != '0) begin
      link.dev_cts_n <= 1'b1;
      cts_hi_cnt <= '0;
    end else if (link.dev_cts_n && cts_hi_cnt != BW'(CPB - 1)) begin
      cts_hi_cnt <= cts_hi_cnt + BW'(1);
    end else begin
      link.dev_cts_n <= 1'b0;
    end
  end

  // Received framing or parity errors are reported and the byte discarded.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_err <= 1'b0;
    end else begin
      o_rx_err <= eng_rx_valid && eng_rx_err;
    end
  end

  bhu_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clear(idle),
    .i_in_valid(i_tx_valid),
    .i_in_data(i_tx_data),
    .o_in_ready(o_tx_ready),
    .o_out_valid(eng_tx_valid),
    .o_out_data(eng_tx_data),
    .i_out_ready(eng_tx_ready),
    .o_level()
  );

  bhu_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clear(idle),
    .i_in_valid(eng_rx_valid && !eng_rx_err),
    .i_in_data(eng_rx_data),
    .o_in_ready(),
    .o_out_valid(o_rx_valid),
    .o_out_data(o_rx_data),
    .i_out_ready(i_rx_ready),
    .o_level(rx_level)
  );

  // The device RTS gates our sends; a character in flight finishes, then we stop.
  bhu_serial #(.DATA_W(DATA_W), .BAUD(BAUD), .PARITY_EN(PARITY_EN), .PARITY_ODD(PARITY_ODD)) u_serial (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clear(idle),
    .i_cts_n(link.dev_rts_n),
    .i_tx_valid(eng_tx_valid),
    .i_tx_data(eng_tx_data),
    .o_tx_ready(eng_tx_ready),
    .o_txd(link.host_txd),
    .i_rxd(link.dev_txd),
    .o_rx_valid(eng_rx_valid),
    .o_rx_data(eng_rx_data),
    .o_rx_err(eng_rx_err)
  );
endmodule

// ===== test/bhu_link_checker.sv
/*
  Wire checker for the link between the device end and the host end.
  Assumes it sits beside the link interface and shares the core clock and reset.
*/
`timescale 1ns/1ps
module bhu_link_checker #(
  parameter int CPB = 10,
  parameter int READY_CYC = 2000
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic dev_txd,
  input wire logic host_txd,
  input wire logic dev_rts_n,
  input wire logic dev_cts_n,
  input wire logic bluetooth_enable_pin,
  input wire logic slow_clock_signal
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  int frame;
  int cts_low;
  int cts_high;
  int rts_high;
  int ready;
  logic rdy_done;
  logic prev_txd;
  logic prev_slow;
  logic slow_seen;
  logic start;

  ////////////////////////////////////////////////////////////////////////////////
  // A fall outside a timed frame is a start bit, so data bits are never taken for one.
  assign start = prev_txd && !dev_txd && (frame == 0);

  // Counters; margins of a few cycles allow for the flop stages of both ends.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_txd <= 1'b1;
      prev_slow <= 1'b0;
      slow_seen <= 1'b0;
      frame <= 0;
      cts_low <= 0;
      cts_high <= 0;
      rts_high <= 0;
      ready <= 0;
      rdy_done <= 1'b0;
    end else begin
      prev_txd <= dev_txd;
      prev_slow <= slow_clock_signal;
      slow_seen <= slow_seen || (prev_slow != slow_clock_signal);
      frame <= start ? 10 * CPB - 1 : (frame > 0 ? frame - 1 : 0);
      cts_low <= dev_cts_n ? 0 : cts_low + 1;
      cts_high <= dev_cts_n ? cts_high + 1 : 0;
      rts_high <= dev_rts_n ? rts_high + 1 : 0;
      ready <= !bluetooth_enable_pin ? 0 : ((dev_rts_n && !rdy_done) ? ready + 1 : ready);
      rdy_done <= bluetooth_enable_pin && (rdy_done || !dev_rts_n);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    start;
  endsequence
  sequence s_start_low;
    !dev_txd [*8];
  endsequence

  AST_START_HELD: assert property (s_start |=> s_start_low)
    else $error("Start bit shorter than a bit time.");
  AST_STOP_BIT: assert property (frame == CPB / 2 |-> dev_txd)
    else $error("Stop bit not high.");
  AST_CTS_LAG: assert property (s_start |-> cts_low >= 99)
    else $error("Frame began before clear-to-send settled low.");
  AST_DEV_STOP: assert property (cts_high > 10 * CPB + 4 |-> dev_txd)
    else $error("Device still sending after clear-to-send rose.");
  AST_HOST_STOP: assert property (rts_high > 10 * CPB + 4 |-> host_txd)
    else $error("Host still sending after request-to-send rose.");
  AST_CTS_PULSE: assert property ($rose(dev_cts_n) |=> dev_cts_n [*8])
    else $error("Clear-to-send pulse shorter than a bit.");
  AST_READY_BOUND: assert property (ready <= READY_CYC + 4)
    else $error("Request-to-send fell too late.");
  AST_READY_EARLY: assert property ($fell(dev_rts_n) && !rdy_done |-> ready >= READY_CYC)
    else $error("Request-to-send fell before power-up ended.");
  AST_RTS_OFF: assert property (!bluetooth_enable_pin [*2] |=> dev_rts_n)
    else $error("Request-to-send low while disabled.");
  AST_SLOW_FIRST: assert property ($rose(bluetooth_enable_pin) |-> slow_seen || prev_slow != slow_clock_signal)
    else $error("Enable raised before the slow clock ran.");
endmodule

// ===== test/test_bt_hci_uart_powerup.sv
/*
  Testbench: device end and host end joined by the link interface, checker beside it.
  Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_bt_hci_uart_powerup;
  localparam int CPB = 16;
  localparam int RDY = 2000;
  logic i_core_clk, i_rst, sup, bt_on, up, pw, drop, h_err;
  logic h_tv, h_tr, h_rv, h_rr, d_tv, d_tr, d_rv, d_rr;
  logic [7:0] h_td, h_rd, d_td, d_rd;
  int errors = 0;
  int checked = 0;
  int bad = 0;
  bhu_link_if link();
  bhu_dev_end #(.BAUD(3_125_000), .READY_CYC(RDY)) bhu_dev_end_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .link(link.dev_end), .i_tx_valid(d_tv), .i_tx_data(d_td), .o_tx_ready(d_tr), .o_rx_valid(d_rv),
    .o_rx_data(d_rd), .i_rx_ready(d_rr), .o_powered(pw), .o_rx_drop(drop));
  bhu_host_end #(.BAUD(3_125_000)) bhu_host_end_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .link(link.host_end), .i_io_supply_good(sup), .i_bt_on(bt_on), .o_link_up(up), .i_tx_valid(h_tv),
    .i_tx_data(h_td), .o_tx_ready(h_tr), .o_rx_valid(h_rv), .o_rx_data(h_rd), .i_rx_ready(h_rr), .o_rx_err(h_err));
  bhu_link_checker #(.CPB(CPB), .READY_CYC(RDY)) bhu_link_checker_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .dev_txd(link.dev_txd), .host_txd(link.host_txd), .dev_rts_n(link.dev_rts_n), .dev_cts_n(link.dev_cts_n),
    .bluetooth_enable_pin(link.bluetooth_enable_pin), .slow_clock_signal(link.slow_clock_signal));

  ////////////////////////////////////////////////////////////////////////////////
  // Dropped or errored bytes are tallied; none is expected anywhere.
  always @(posedge i_core_clk) begin
    if (drop === 1'b1 || h_err === 1'b1) bad++;
  end

  // Valid-ready pushes and pops; dev selects the device end.
  task automatic send(input bit dev, input logic [7:0] b);
    @(negedge i_core_clk);
    if (dev) {d_tv, d_td} = {1'b1, b};
    else {h_tv, h_td} = {1'b1, b};
    do @(posedge i_core_clk); while ((dev ? d_tr : h_tr) !== 1'b1);
    @(negedge i_core_clk);
    if (dev) d_tv = 1'b0;
    else h_tv = 1'b0;
  endtask

  task automatic recv(input bit dev, input logic [7:0] b);
    @(negedge i_core_clk);
    if (dev) d_rr = 1'b1;
    else h_rr = 1'b1;
    do @(posedge i_core_clk); while ((dev ? d_rv : h_rv) !== 1'b1);
    `CHK("rx byte", b, dev ? d_rd : h_rd)
    @(negedge i_core_clk);
    if (dev) d_rr = 1'b0;
    else h_rr = 1'b0;
  endtask

  // Samples each bit of one frame mid-bit on the chosen line.
  task automatic wire_chk(input bit dev, input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    do @(posedge i_core_clk); while ((dev ? link.dev_txd : link.host_txd) !== 1'b0);
    repeat (CPB / 2) @(posedge i_core_clk);
    for (int i = 0; i < 10; i++) begin
      `CHK("line bit", fr[i], dev ? link.dev_txd : link.host_txd)
      repeat (CPB) @(posedge i_core_clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    int n;
    `CHK("rts idle", 1'b1, link.dev_rts_n)
    @(negedge i_core_clk);
    sup = 1'b1;
    bt_on = 1'b1;
    wait (link.bluetooth_enable_pin === 1'b1);
    n = 0;
    while (link.dev_rts_n !== 1'b0 && n < 5000) begin
      @(posedge i_core_clk);
      n++;
    end
    `CHK("rts late", 1'b1, n <= RDY + 4)
    `CHK("rts early", 1'b1, n >= RDY)
    repeat (3) @(posedge i_core_clk);
    `CHK("link up", 1'b1, up)
  endtask

  task automatic t_d2h();
    fork
      send(1'b1, 8'h5a);
      wire_chk(1'b1, 8'h5a);
    join
    recv(1'b0, 8'h5a);
  endtask

  task automatic t_h2d();
    fork
      send(1'b0, 8'h81);
      wire_chk(1'b0, 8'h81);
    join
    recv(1'b1, 8'h81);
  endtask

  // Device buffer fills to three quarters while unread; the host must hold off until it is read below that level.
  task automatic t_rx_full();
    fork
      for (int i = 0; i < 8; i++) send(1'b0, 8'(i * 37));
    join_none
    wait (link.dev_rts_n === 1'b1);
    repeat (30 * CPB) @(posedge i_core_clk);
    `CHK("rts held", 1'b1, link.dev_rts_n)
    for (int i = 0; i < 8; i++) recv(1'b1, 8'(i * 37));
    wait fork;
    `CHK("no drop", 0, bad)
  endtask

  // Host stays unread, so the device must pause on clear-to-send and lose nothing.
  task automatic t_tx_hold();
    fork
      for (int i = 0; i < 5; i++) send(1'b1, 8'hff - 8'(i));
    join_none
    repeat (60 * CPB) @(posedge i_core_clk);
    `CHK("cts held", 1'b1, link.dev_cts_n)
    for (int i = 0; i < 5; i++) recv(1'b0, 8'hff - 8'(i));
    wait fork;
    `CHK("no error", 0, bad)
  endtask

  task automatic t_off();
    @(negedge i_core_clk);
    bt_on = 1'b0;
    repeat (5) @(posedge i_core_clk);
    `CHK("rts off", 1'b1, link.dev_rts_n)
    `CHK("powered off", 1'b0, pw)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Clock at 50 MHz.
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  // Power-up and traffic need under ten thousand cycles; thirty thousand means a hang.
  initial begin
    #(30_000 * 20);
    errors++;
    print_verdict();
  end

  initial begin
    {sup, bt_on, h_tv, h_rr, d_tv, d_rr} = '0;
    h_td = '0;
    d_td = '0;
    i_rst = 1'b1;
    repeat (10) @(negedge i_core_clk);
    i_rst = 1'b0;
    t_power();
    t_d2h();
    t_h2d();
    t_rx_full();
    t_tx_hold();
    t_off();
    print_verdict();
  end
endmodule
